// [src/csl_flasher.sv]
`timescale 1ns/1ns
// ==========================================================
// Free-running half-period toggle
module csl_flasher #(
    parameter int HALF_CYC = 1000
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // Phase
    output logic      phase
);
    initial
    begin
        if (HALF_CYC < 1)
            $error("csl_flasher: HALF_CYC must be at least 1");
    end

    typedef struct packed {
        logic [31:0] cnt;
        logic        phase;
    } csl_flash_st_t;

    csl_flash_st_t st;
    csl_flash_st_t next_st;

    always_comb
    begin
        next_st = st;
        if (st.cnt >= 32'(HALF_CYC - 1))
        begin
            next_st.cnt   = 32'h0;
            next_st.phase = ~st.phase;
        end
        else
            next_st.cnt = st.cnt + 32'h1;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            st <= '0;
        else
            st <= next_st;
    end

    assign phase = st.phase;
endmodule : csl_flasher

// [src/csl_pkg.sv]
package csl_pkg;

    // ==========================================================
    // LED colour and pattern
    typedef enum logic [1:0] {
        CSL_OFF   = 2'h0,
        CSL_RED   = 2'h1,
        CSL_BLUE  = 2'h2,
        CSL_GREEN = 2'h3
    } csl_colour_t;

    typedef enum logic [1:0] {
        CSL_STEADY = 2'h0,
        CSL_SLOW   = 2'h1,
        CSL_FAST   = 2'h2
    } csl_pattern_t;

    typedef struct packed {
        csl_colour_t  colour;
        csl_pattern_t pattern;
    } csl_ind_t;

    // ==========================================================
    // Condition flags from the rest of the camera
    typedef struct packed {
        logic init_done;
        logic init_fault;
        logic over_temp;
        logic link_up;
        logic app_connected;
        logic acq_triggered;
        logic acq_free_run;
    } csl_cond_t;

    // ==========================================================
    // Address configuration sequencer
    typedef enum logic [2:0] {
        CSL_IDLE       = 3'h0,
        CSL_PERSIST    = 3'h1,
        CSL_DHCP       = 3'h3,
        CSL_LINK_LOCAL = 3'h2,
        CSL_ASSIGNED   = 3'h6
    } csl_ip_state_t;

    // Method bits of the start-request
    localparam logic [1:0] CSL_METH_PERSIST = 2'h1;
    localparam logic [1:0] CSL_METH_DHCP    = 2'h2;
    localparam logic [1:0] CSL_METH_LLA     = 2'h3;

    // Factory defaults of the method enables
    localparam logic CSL_PERSIST_EN_DFLT = 1'b0;
    localparam logic CSL_DHCP_EN_DFLT    = 1'b1;

    // Flash timing
    localparam int CSL_CLK_HZ       = 10_000_000;
    localparam int CSL_SLOW_HALF_MS = 500;
    localparam int CSL_FAST_HALF_MS = 125;
    localparam int CSL_SLOW_HALF_CYC = CSL_CLK_HZ / 1000 * CSL_SLOW_HALF_MS;
    localparam int CSL_FAST_HALF_CYC = CSL_CLK_HZ / 1000 * CSL_FAST_HALF_MS;

endpackage : csl_pkg

// [src/csl_status_seq.sv]
`timescale 1ns/1ns
module csl_status_seq #(
    parameter int SLOW_HALF_CYC = csl_pkg::CSL_SLOW_HALF_CYC,
    parameter int FAST_HALF_CYC = csl_pkg::CSL_FAST_HALF_CYC
) (
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    // Camera conditions
    input  wire csl_pkg::csl_cond_t   cond,
    // Method enables and factory reset
    input  wire logic                 persist_en_wr,
    input  wire logic                 persist_en_val,
    input  wire logic                 dhcp_en_wr,
    input  wire logic                 dhcp_en_val,
    input  wire logic                 factory_reset,
    // Results from the network stack
    input  wire logic                 method_ok,
    input  wire logic                 method_fail,
    // Address sequencer outputs
    output logic                      method_start,
    output logic [1:0]                method_sel,
    output logic                      ip_assigned,
    output logic                      host_accept,
    output logic                      persist_en,
    output logic                      dhcp_en,
    // Status LED
    output csl_pkg::csl_ind_t         led_ind,
    output logic                      led_red,
    output logic                      led_green,
    output logic                      led_blue
);
    initial
    begin
        if (SLOW_HALF_CYC <= FAST_HALF_CYC || FAST_HALF_CYC < 1)
            $error("csl_status_seq: slow flash must be slower than fast flash");
    end

    // ==========================================================
    // Flash phases
    logic slow_ph;
    logic fast_ph;

    csl_flasher #(.HALF_CYC(SLOW_HALF_CYC)) u_slow (
        .clock (clock),
        .rst_n (rst_n),
        .phase (slow_ph)
    );

    csl_flasher #(.HALF_CYC(FAST_HALF_CYC)) u_fast (
        .clock (clock),
        .rst_n (rst_n),
        .phase (fast_ph)
    );

    // ==========================================================
    // State
    typedef struct packed {
        csl_pkg::csl_ip_state_t ip;
        logic                   persist_en;
        logic                   dhcp_en;
        logic                   link_q;
        logic                   started;
        logic                   start;
        logic [1:0]             sel;
        csl_pkg::csl_ind_t      ind;
        logic                   r;
        logic                   g;
        logic                   b;
        logic                   accept;
    } csl_st_t;

    csl_st_t st;
    csl_st_t next_st;

    csl_pkg::csl_ind_t sel_ind;
    logic              lit;

    // Priority order, highest first
    always_comb
    begin
        sel_ind = '{csl_pkg::CSL_RED, csl_pkg::CSL_STEADY};
        if (cond.over_temp)
            sel_ind = '{csl_pkg::CSL_RED, csl_pkg::CSL_FAST};
        else if (cond.init_fault)
            sel_ind = '{csl_pkg::CSL_RED, csl_pkg::CSL_SLOW};
        else if (!cond.init_done)
            sel_ind = '{csl_pkg::CSL_RED, csl_pkg::CSL_STEADY};
        else if (!cond.link_up)
            sel_ind = '{csl_pkg::CSL_BLUE, csl_pkg::CSL_FAST};
        else if (st.ip != csl_pkg::CSL_ASSIGNED)
            sel_ind = '{csl_pkg::CSL_BLUE, csl_pkg::CSL_SLOW};
        else if (cond.acq_free_run)
            sel_ind = '{csl_pkg::CSL_GREEN, csl_pkg::CSL_FAST};
        else if (cond.acq_triggered)
            sel_ind = '{csl_pkg::CSL_GREEN, csl_pkg::CSL_SLOW};
        else if (cond.app_connected)
            sel_ind = '{csl_pkg::CSL_GREEN, csl_pkg::CSL_STEADY};
        else
            sel_ind = '{csl_pkg::CSL_BLUE, csl_pkg::CSL_STEADY};
    end

    always_comb
    begin
        unique case (sel_ind.pattern)
            csl_pkg::CSL_SLOW: lit = slow_ph;
            csl_pkg::CSL_FAST: lit = fast_ph;
            default:           lit = 1'b1;
        endcase
    end

    always_comb
    begin
        next_st        = st;
        next_st.start  = 1'b0;
        next_st.link_q = cond.link_up;
        next_st.ind    = sel_ind;
        next_st.r      = lit && sel_ind.colour == csl_pkg::CSL_RED;
        next_st.g      = lit && sel_ind.colour == csl_pkg::CSL_GREEN;
        next_st.b      = lit && sel_ind.colour == csl_pkg::CSL_BLUE;

        // Method enables; link-local has no enable at all
        if (factory_reset)
        begin
            next_st.persist_en = csl_pkg::CSL_PERSIST_EN_DFLT;
            next_st.dhcp_en    = csl_pkg::CSL_DHCP_EN_DFLT;
        end
        else
        begin
            if (persist_en_wr)
                next_st.persist_en = persist_en_val;
            if (dhcp_en_wr)
                next_st.dhcp_en = dhcp_en_val;
        end

        // Link loss drops the address; a fresh link restarts the sequence
        if (!cond.link_up)
        begin
            next_st.ip      = csl_pkg::CSL_IDLE;
            next_st.started = 1'b0;
        end
        else if (!st.started || !st.link_q)
        begin
            next_st.started = 1'b1;
            next_st.start   = 1'b1;
            if (st.persist_en)
            begin
                next_st.ip  = csl_pkg::CSL_PERSIST;
                next_st.sel = csl_pkg::CSL_METH_PERSIST;
            end
            else if (st.dhcp_en)
            begin
                next_st.ip  = csl_pkg::CSL_DHCP;
                next_st.sel = csl_pkg::CSL_METH_DHCP;
            end
            else
            begin
                next_st.ip  = csl_pkg::CSL_LINK_LOCAL;
                next_st.sel = csl_pkg::CSL_METH_LLA;
            end
        end
        else
        begin
            unique case (st.ip)
                csl_pkg::CSL_PERSIST:
                    if (method_ok)
                        next_st.ip = csl_pkg::CSL_ASSIGNED;
                    else if (method_fail)
                    begin
                        next_st.start = 1'b1;
                        next_st.ip    = st.dhcp_en ? csl_pkg::CSL_DHCP : csl_pkg::CSL_LINK_LOCAL;
                        next_st.sel   = st.dhcp_en ? csl_pkg::CSL_METH_DHCP : csl_pkg::CSL_METH_LLA;
                    end
                csl_pkg::CSL_DHCP:
                    if (method_ok)
                        next_st.ip = csl_pkg::CSL_ASSIGNED;
                    else if (method_fail)
                    begin
                        next_st.start = 1'b1;
                        next_st.ip    = csl_pkg::CSL_LINK_LOCAL;
                        next_st.sel   = csl_pkg::CSL_METH_LLA;
                    end
                csl_pkg::CSL_LINK_LOCAL:
                    // Link-local retries with a new address until it sticks
                    if (method_ok)
                        next_st.ip = csl_pkg::CSL_ASSIGNED;
                    else if (method_fail)
                        next_st.start = 1'b1;
                default:
                    next_st.ip = st.ip;
            endcase
        end
        next_st.accept = next_st.ip == csl_pkg::CSL_ASSIGNED;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st            <= '0;
            st.persist_en <= csl_pkg::CSL_PERSIST_EN_DFLT;
            st.dhcp_en    <= csl_pkg::CSL_DHCP_EN_DFLT;
            st.ind        <= '{csl_pkg::CSL_RED, csl_pkg::CSL_STEADY};
        end
        else
            st <= next_st;
    end

    assign method_start = st.start;
    assign method_sel   = st.sel;
    // Same flop as host_accept so the output comes straight from a register
    assign ip_assigned  = st.accept;
    assign host_accept  = st.accept;
    assign persist_en   = st.persist_en;
    assign dhcp_en      = st.dhcp_en;
    assign led_ind      = st.ind;
    assign led_red      = st.r;
    assign led_green    = st.g;
    assign led_blue     = st.b;

    // ==========================================================
    // Checks
    AST_ACCEPT_ONLY_ASSIGNED: assert property (@(posedge clock) disable iff (!rst_n)
        host_accept |-> st.ip == csl_pkg::CSL_ASSIGNED)
        else $error("host accepted without address");
    AST_HOT_FAST_RED: assert property (@(posedge clock) disable iff (!rst_n)
        cond.over_temp |=> led_ind == csl_pkg::csl_ind_t'{csl_pkg::CSL_RED, csl_pkg::CSL_FAST})
        else $error("overtemp not fast red");
    AST_NOLINK_FAST_BLUE: assert property (@(posedge clock) disable iff (!rst_n)
        (cond.init_done && !cond.init_fault && !cond.over_temp && !cond.link_up)
        |=> led_ind == csl_pkg::csl_ind_t'{csl_pkg::CSL_BLUE, csl_pkg::CSL_FAST})
        else $error("link down not fast blue");
    AST_LINKUP_STARTS: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(cond.link_up) |=> method_start)
        else $error("link-up did not start sequence");
    AST_PERSIST_FIRST: assert property (@(posedge clock) disable iff (!rst_n)
        (method_start && $past(st.ip) == csl_pkg::CSL_IDLE && $past(persist_en))
        |-> method_sel == csl_pkg::CSL_METH_PERSIST)
        else $error("persistent not tried first");
    AST_FACTORY: assert property (@(posedge clock) disable iff (!rst_n)
        factory_reset |=> !persist_en && dhcp_en)
        else $error("factory defaults wrong");
    AST_ACQ_OVER_IP: assert property (@(posedge clock) disable iff (!rst_n)
        (ip_assigned && cond.link_up && cond.init_done && !cond.init_fault && !cond.over_temp
         && cond.acq_free_run) |=> led_ind.colour == csl_pkg::CSL_GREEN)
        else $error("acquisition not above address");
    AST_WAIT_SLOW_BLUE: assert property (@(posedge clock) disable iff (!rst_n)
        (cond.init_done && !cond.init_fault && !cond.over_temp && cond.link_up
         && st.ip != csl_pkg::CSL_ASSIGNED)
        |=> led_ind == csl_pkg::csl_ind_t'{csl_pkg::CSL_BLUE, csl_pkg::CSL_SLOW})
        else $error("waiting not slow blue");
    AST_IDLE_STEADY_BLUE: assert property (@(posedge clock) disable iff (!rst_n)
        (cond.init_done && !cond.init_fault && !cond.over_temp && cond.link_up && ip_assigned
         && !cond.app_connected && !cond.acq_free_run && !cond.acq_triggered)
        |=> led_ind == csl_pkg::csl_ind_t'{csl_pkg::CSL_BLUE, csl_pkg::CSL_STEADY} && led_blue)
        else $error("assigned idle not steady blue");
endmodule : csl_status_seq

// [verif/csl_net_model.sv]
`timescale 1ns/1ns
// ==========================================================
// Network stack stand-in: answers each method after a delay
module csl_net_model #(
    parameter int DELAY = 6
) (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // Request from the sequencer
    input  wire logic       method_start,
    input  wire logic [1:0] method_sel,
    // Scenario knobs
    input  wire logic       persist_works,
    input  wire logic       dhcp_server,
    // Results
    output logic            method_ok,
    output logic            method_fail
);
    int         cnt;
    logic [1:0] sel;
    logic       good;

    // Link-local always succeeds here, so its retry path is not exercised
    assign good = (sel == csl_pkg::CSL_METH_PERSIST) ? persist_works :
                  (sel == csl_pkg::CSL_METH_DHCP) ? dhcp_server : 1'b1;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt         <= 0;
            sel         <= 2'h0;
            method_ok   <= 1'b0;
            method_fail <= 1'b0;
        end
        else
        begin
            method_ok   <= 1'b0;
            method_fail <= 1'b0;
            if (method_start)
            begin
                cnt <= DELAY;
                sel <= method_sel;
            end
            else if (cnt == 1)
            begin
                method_ok   <= good;
                method_fail <= !good;
                cnt         <= 0;
            end
            else if (cnt > 1)
                cnt <= cnt - 1;
        end
    end
endmodule : csl_net_model

// [verif/testbench.sv]
`timescale 1ns/1ns
`define CHK(nm, e, g) chk(nm, 8'(e), 8'(g))
module testbench;
    logic               clock = 1'b0;
    logic               rst_n = 1'b0;
    csl_pkg::csl_cond_t cond = '0;
    logic               persist_en_wr = 1'b0;
    logic               persist_en_val = 1'b0;
    logic               dhcp_en_wr = 1'b0;
    logic               dhcp_en_val = 1'b0;
    logic               factory_reset = 1'b0;
    logic               persist_works = 1'b0;
    logic               dhcp_server = 1'b1;
    logic               method_ok, method_fail, method_start, ip_assigned, host_accept;
    logic               persist_en, dhcp_en, led_red, led_green, led_blue;
    logic [1:0]         method_sel;
    csl_pkg::csl_ind_t  led_ind;
    logic [5:0]         seq_log = '0;
    logic [1:0]         seq_n = '0;
    int                 err_total = 0;
    int                 checks = 0;
    int                 lit_n = 0;
    // Rows: conditions, expected {colour, pattern}
    logic [6:0]         row_cond [7] = '{7'h7f, 7'h6f, 7'h4f, 7'h4e, 7'h4c, 7'h48, 7'h08};
    logic [3:0]         row_ind [7] = '{4'h6, 4'h5, 4'he, 4'hd, 4'hc, 4'h8, 4'h4};

    always #50 clock = ~clock;

    csl_status_seq #(.SLOW_HALF_CYC(8), .FAST_HALF_CYC(3)) dut_u (
        .clock(clock), .rst_n(rst_n), .cond(cond),
        .persist_en_wr(persist_en_wr), .persist_en_val(persist_en_val),
        .dhcp_en_wr(dhcp_en_wr), .dhcp_en_val(dhcp_en_val), .factory_reset(factory_reset),
        .method_ok(method_ok), .method_fail(method_fail), .method_start(method_start),
        .method_sel(method_sel), .ip_assigned(ip_assigned), .host_accept(host_accept),
        .persist_en(persist_en), .dhcp_en(dhcp_en), .led_ind(led_ind),
        .led_red(led_red), .led_green(led_green), .led_blue(led_blue));

    csl_net_model #(.DELAY(6)) net_u (
        .clock(clock), .rst_n(rst_n), .method_start(method_start), .method_sel(method_sel),
        .persist_works(persist_works), .dhcp_server(dhcp_server),
        .method_ok(method_ok), .method_fail(method_fail));

    // Log of methods tried, newest in the low bits
    always @(posedge clock)
        if (method_start === 1'b1)
        begin
            seq_log <= {seq_log[3:0], method_sel};
            seq_n   <= seq_n + 2'd1;
        end

    // ==========================================================
    // Helpers
    task tick(input int n);
        repeat (n) @(posedge clock);
        #10;
    endtask : tick

    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    task wait_ip;
        int i;
        for (i = 0; i < 200 && ip_assigned !== 1'b1; i++)
            tick(1);
        if (ip_assigned !== 1'b1)
        begin
            err_total++;
            $display("BAD ip_assigned expected 1 seen %b", ip_assigned);
            tally_and_finish();
        end
    endtask : wait_ip

    // Link bounce restarts the address sequence
    task relink;
        cond.link_up = 1'b0;
        tick(3);
        seq_log = '0;
        seq_n = '0;
        cond.link_up = 1'b1;
        wait_ip();
        tick(3);
    endtask : relink

    // ==========================================================
    // Sequence
    initial
    begin
        tick(10);
        rst_n = 1'b1;
        tick(2);
        `CHK("ind_reset", 4'h4, led_ind);
        `CHK("lamps_reset", 3'b100, {led_red, led_green, led_blue});
        `CHK("persist_dflt", 1'b0, persist_en);
        `CHK("dhcp_dflt", 1'b1, dhcp_en);
        $display("test reset done");
        cond.init_done = 1'b1;
        cond.link_up = 1'b1;
        tick(4);
        `CHK("ind_wait", 4'h9, led_ind);
        `CHK("accept_wait", 1'b0, host_accept);
        wait_ip();
        tick(3);
        `CHK("seq_first", {2'd1, 4'h0, csl_pkg::CSL_METH_DHCP}, {seq_n, seq_log});
        `CHK("accept", 1'b1, host_accept);
        `CHK("ind_assigned", 4'h8, led_ind);
        `CHK("lamps_assigned", 3'b001, {led_red, led_green, led_blue});
        $display("test first address done");
        for (int i = 0; i < 7; i++)
        begin
            cond = row_cond[i];
            tick(3);
            `CHK("ind_row", row_ind[i], led_ind);
        end
        $display("test priority rows done");
        // Fast half period is 3 cycles, so any 12 samples hold 6 lit ones
        cond = 7'h49;
        tick(3);
        lit_n = 0;
        for (int i = 0; i < 12; i++)
        begin
            lit_n += (led_green === 1'b1) ? 1 : 0;
            tick(1);
        end
        `CHK("green_fast_duty", 8'd6, lit_n);
        `CHK("lamps_not_green", 2'b00, {led_red, led_blue});
        $display("test flash done");
        cond = 7'h48;
        tick(3);
        cond.link_up = 1'b0;
        tick(3);
        `CHK("ind_nolink", 4'ha, led_ind);
        `CHK("accept_nolink", 1'b0, host_accept);
        $display("test link down done");
        persist_en_wr = 1'b1;
        persist_en_val = 1'b1;
        dhcp_server = 1'b0;
        tick(1);
        persist_en_wr = 1'b0;
        tick(1);
        `CHK("persist_wr", 1'b1, persist_en);
        relink();
        `CHK("seq_all", {2'd3, 2'h1, 2'h2, 2'h3}, {seq_n, seq_log});
        dhcp_en_wr = 1'b1;
        dhcp_en_val = 1'b0;
        dhcp_server = 1'b1;
        tick(1);
        dhcp_en_wr = 1'b0;
        relink();
        `CHK("seq_skip_dhcp", {2'd2, 2'h0, 2'h1, 2'h3}, {seq_n, seq_log});
        persist_works = 1'b1;
        relink();
        `CHK("seq_persist", {2'd1, 4'h0, 2'h1}, {seq_n, seq_log});
        $display("test method order done");
        // Factory reset must win over writes in the same cycle
        factory_reset = 1'b1;
        persist_en_wr = 1'b1;
        dhcp_en_wr = 1'b1;
        tick(1);
        factory_reset = 1'b0;
        persist_en_wr = 1'b0;
        dhcp_en_wr = 1'b0;
        tick(1);
        `CHK("persist_factory", 1'b0, persist_en);
        `CHK("dhcp_factory", 1'b1, dhcp_en);
        $display("test factory reset done");
        rst_n = 1'b0;
        tick(10);
        seq_log = '0;
        seq_n = '0;
        rst_n = 1'b1;
        wait_ip();
        tick(1);
        `CHK("seq_powerup", {2'd1, 4'h0, csl_pkg::CSL_METH_DHCP}, {seq_n, seq_log});
        $display("test power-up start done");
        tally_and_finish();
    end
endmodule : testbench
